// ==== common/ssm_defs.svh ====
// Register offsets, field positions, reset values and timing counts for the serial master.
// Assumes inclusion by bare name from the include path.
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH
`define SSM_OFF_BAUDCON 8'h00
`define SSM_OFF_RCSTA 8'h04
`define SSM_OFF_DIVLO 8'h08
`define SSM_OFF_DIVHI 8'h0c
`define SSM_OFF_TXHOLD 8'h10
`define SSM_OFF_TXSTA 8'h14
`define SSM_OFF_RXDATA 8'h18
// baud_control fields
`define SSM_BC_DPOL 5
`define SSM_BC_CPOL 4
`define SSM_BC_WIDE 3
`define SSM_BC_WAKE 1
`define SSM_BC_ABD 0
// receive_status_control fields
`define SSM_RS_PORT_ON 7
`define SSM_RS_RX_ONE 5
`define SSM_RS_RX_CONT 4
`define SSM_RS_FRAME_ERR 2
`define SSM_RS_RCIF 1
// transmit_status_control fields
`define SSM_TS_MASTER 7
`define SSM_TS_NINE_ON 6
`define SSM_TS_TX_ON 5
`define SSM_TS_SYNC 4
`define SSM_TS_HIGH_SPD 2
`define SSM_TS_TRMT 1
`define SSM_TS_NINE_VAL 0
`define SSM_RST_BYTE 8'h00
`define SSM_RST_TXSTA 8'h02
`define SSM_BREAK_DATA 8'h00
`define SSM_BREAK_ZEROS 12
`endif

// ==== common/ssm_pkg.sv ====
// Types shared by the serial master files.
// Assumes nothing of its surroundings.
package ssm_pkg;
    typedef enum logic [1:0] {SSM_IDLE, SSM_LEAD, SSM_TRAIL} ssm_shift_type;
endpackage

// ==== rtl/ssm_sync2.sv ====
// Two-flop synchroniser for one asynchronous level.
// Assumes a single clock domain on aclk.
`timescale 1ns/1ns
module ssm_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    // First stage is read only by the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// ==== rtl/ssm_baud.sv ====
// Baud generator: emits one tick per half bit period.
// Assumes divisor and speed bits are steady while a character shifts.
`timescale 1ns/1ns
module ssm_baud (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [15:0] divisor,
    input wire logic wide_sel,
    input wire logic high_sel,
    output logic half_tick
);
    logic [21:0] cnt_ff;
    logic [21:0] reload;
    // Base prescale of 4, 16 or 64 clocks per count; halved for clock phases
    always_comb begin
        reload = {6'h00, (wide_sel ? divisor : {8'h00, divisor[7:0]})} + 22'h000001;
        if (wide_sel && high_sel) begin
            reload = reload << 1;
        end else if (wide_sel || high_sel) begin
            reload = reload << 3;
        end else begin
            reload = reload << 5;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_ff <= 22'h000000;
            half_tick <= 1'b0;
        end else if (cnt_ff + 22'h000001 >= reload) begin
            cnt_ff <= 22'h000000;
            half_tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 22'h000001;
            half_tick <= 1'b0;
        end
    end
endmodule

// ==== rtl/ssm_top.sv ====
// Synchronous serial master transmitter with break detection on the receive line while a character shifts out.
// Assumes an AXI4-Lite master on aclk and asynchronous pins sampled through synchronisers.
`timescale 1ns/1ns
`include "ssm_defs.svh"
// Overview of operation
// - Break seen when receive flag, framing error and zero data coincide
// - Wake-on-break: two line transitions, interrupt, next byte, second interrupt (code: one interrupt on the falling edge, no byte received)
// - One data line and one clock line, never sending and receiving together
// - No start or stop bits in synchronous mode
// - Master mode needs sync, clock source and port enable all set
// - Either receive enable set selects receive instead of transmit
// - Clock pin driver enabled whenever synchronous master is configured
// - Exactly one clock cycle per data bit
// - Data changes on leading edge, sampled on trailing edge
// - Polarity set: clock idles high, data changes on falling edge
// - Polarity clear: clock idles low, data changes on rising edge
// - Transmit enables drivers on both data and clock pins
// - Holding register waits while shift register still busy
// - Empty shift register loads at once and shifting starts
// - Each bit held from one leading edge to the next
// - Shift register has no software address
// - Data polarity resets to zero; set inverts transmit and receive data
// - No transmission unless transmit enable set
// - Break is start bit, twelve zero bits, stop bit (code: twelve zero samples at half-bit ticks while shifting, then a rise)
// - Wake enable cleared by rising receive edge ending the break
module ssm_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe
);
    logic [7:0] baud_control_ff, receive_status_control_ff, transmit_status_control_ff;
    logic [7:0] baud_divisor_low_ff, baud_divisor_high_ff, hold_ff, rx_data_ff;
    logic hold_full_ff, hold_ninth_ff;
    logic [8:0] shreg_ff;
    logic [3:0] bits_left_ff;
    logic shreg_busy_ff;
    logic rx_event, brk_frame;
    ssm_pkg::ssm_shift_type state_ff;
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic half_tick, rx_sync, rx_prev_ff;
    logic master_on, tx_mode, wr_go, rd_go;
    logic [3:0] brk_cnt_ff;
    logic [1:0] wake_edges_ff;
    logic rx_bit;

    assign master_on = transmit_status_control_ff[`SSM_TS_SYNC]
        && transmit_status_control_ff[`SSM_TS_MASTER]
        && receive_status_control_ff[`SSM_RS_PORT_ON];
    assign tx_mode = master_on && !receive_status_control_ff[`SSM_RS_RX_ONE]
        && !receive_status_control_ff[`SSM_RS_RX_CONT]
        && transmit_status_control_ff[`SSM_TS_TX_ON];
    assign wr_go = aw_ff && w_ff && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    ssm_sync2 #(.RST_VAL(1'b1)) u_rx_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(serial_data_pin_i),
        .sync_out(rx_sync)
    );

    ssm_baud u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(shreg_busy_ff),
        .divisor({baud_divisor_high_ff, baud_divisor_low_ff}),
        .wide_sel(baud_control_ff[`SSM_BC_WIDE]),
        .high_sel(transmit_status_control_ff[`SSM_TS_HIGH_SPD]),
        .half_tick(half_tick)
    );

    // Write address and data channels latch independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_go) begin
                w_ff <= 1'b0;
            end
        end
    end

    // Ready while the matching slot is empty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_ff && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_ff && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_ff > `SSM_OFF_RXDATA || awaddr_ff[1:0] != 2'h0)
                ? 2'h2 : 2'h0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration registers; lane 0 carries each byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_control_ff <= `SSM_RST_BYTE;
            baud_divisor_low_ff <= `SSM_RST_BYTE;
            baud_divisor_high_ff <= `SSM_RST_BYTE;
            transmit_status_control_ff <= `SSM_RST_TXSTA;
            receive_status_control_ff <= `SSM_RST_BYTE;
        end else begin
            if (wr_go && wstrb_ff[0]) begin
                unique case (awaddr_ff)
                    `SSM_OFF_BAUDCON: baud_control_ff <= wdata_ff[7:0];
                    `SSM_OFF_DIVLO: baud_divisor_low_ff <= wdata_ff[7:0];
                    `SSM_OFF_DIVHI: baud_divisor_high_ff <= wdata_ff[7:0];
                    `SSM_OFF_TXSTA: transmit_status_control_ff <= {wdata_ff[7:2],
                        transmit_status_control_ff[`SSM_TS_TRMT], wdata_ff[0]};
                    `SSM_OFF_RCSTA: receive_status_control_ff <= {wdata_ff[7:3],
                        receive_status_control_ff[2:1], wdata_ff[0]};
                    default: ;
                endcase
            end
            // Shift register empty flag tracks hardware, not software
            transmit_status_control_ff[`SSM_TS_TRMT] <= !shreg_busy_ff;
            // Wake enable falls with the rising edge that ends the break
            if (baud_control_ff[`SSM_BC_WAKE] && rx_sync && !rx_prev_ff) begin
                baud_control_ff[`SSM_BC_WAKE] <= 1'b0;
            end
            // Receive flag: hardware set wins over a reading clear
            if (rx_event) begin
                receive_status_control_ff[`SSM_RS_RCIF] <= 1'b1;
                receive_status_control_ff[`SSM_RS_FRAME_ERR] <= brk_frame;
            end else if (rd_go && s_axi_araddr == `SSM_OFF_RXDATA) begin
                receive_status_control_ff[`SSM_RS_RCIF] <= 1'b0;
            end
        end
    end

    // Break watch on the receive line: twelve or more zero samples then a rise
    assign rx_bit = rx_sync ^ baud_control_ff[`SSM_BC_DPOL];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_prev_ff <= 1'b1;
            brk_cnt_ff <= 4'h0;
            wake_edges_ff <= 2'h0;
            rx_data_ff <= 8'h00;
        end else begin
            rx_prev_ff <= rx_sync;
            if (half_tick && !rx_bit && brk_cnt_ff != 4'hf) begin
                brk_cnt_ff <= brk_cnt_ff + 4'h1;
            end else if (rx_bit) begin
                brk_cnt_ff <= 4'h0;
            end
            // Two transitions counted while wake is armed
            if (baud_control_ff[`SSM_BC_WAKE] && rx_sync != rx_prev_ff) begin
                wake_edges_ff <= wake_edges_ff + 2'h1;
            end else if (!baud_control_ff[`SSM_BC_WAKE]) begin
                wake_edges_ff <= 2'h0;
            end
            if (brk_frame) begin
                rx_data_ff <= `SSM_BREAK_DATA;
            end
        end
    end
    // Break framing: zero run long enough ends as the line rises
    assign brk_frame = rx_bit && !(rx_prev_ff ^ baud_control_ff[`SSM_BC_DPOL])
        && brk_cnt_ff >= 4'(`SSM_BREAK_ZEROS);
    assign rx_event = brk_frame
        || (baud_control_ff[`SSM_BC_WAKE] && !rx_sync && rx_prev_ff);

    // Holding register: loads on write, hands over when shifter free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_ff <= 8'h00;
            hold_ninth_ff <= 1'b0;
            hold_full_ff <= 1'b0;
        end else if (wr_go && wstrb_ff[0] && awaddr_ff == `SSM_OFF_TXHOLD) begin
            hold_ff <= wdata_ff[7:0];
            hold_ninth_ff <= transmit_status_control_ff[`SSM_TS_NINE_VAL];
            hold_full_ff <= 1'b1;
        end else if (hold_full_ff && !shreg_busy_ff && tx_mode) begin
            hold_full_ff <= 1'b0;
        end
    end

    // Shifter: idle, lead half, trail half per bit, no start or stop bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ssm_pkg::SSM_IDLE;
            shreg_ff <= 9'h000;
            bits_left_ff <= 4'h0;
            shreg_busy_ff <= 1'b0;
        end else if (!tx_mode) begin
            state_ff <= ssm_pkg::SSM_IDLE;
            shreg_busy_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ssm_pkg::SSM_IDLE: begin
                    if (hold_full_ff) begin
                        shreg_ff <= {hold_ninth_ff, hold_ff};
                        bits_left_ff <= transmit_status_control_ff[`SSM_TS_NINE_ON]
                            ? 4'h9 : 4'h8;
                        shreg_busy_ff <= 1'b1;
                        state_ff <= ssm_pkg::SSM_LEAD;
                    end
                end
                ssm_pkg::SSM_LEAD: begin
                    if (half_tick) begin
                        state_ff <= ssm_pkg::SSM_TRAIL;
                    end
                end
                ssm_pkg::SSM_TRAIL: begin
                    if (half_tick) begin
                        shreg_ff <= {1'b0, shreg_ff[8:1]};
                        bits_left_ff <= bits_left_ff - 4'h1;
                        if (bits_left_ff == 4'h1) begin
                            shreg_busy_ff <= 1'b0;
                            state_ff <= ssm_pkg::SSM_IDLE;
                        end else begin
                            state_ff <= ssm_pkg::SSM_LEAD;
                        end
                    end
                end
            endcase
        end
    end

    // Pins: clock high during lead half, then inverted by polarity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
            serial_data_pin_o <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end else begin
            serial_clock_pin_o <= (state_ff == ssm_pkg::SSM_LEAD)
                ^ baud_control_ff[`SSM_BC_CPOL];
            serial_clock_pin_oe <= master_on;
            serial_data_pin_o <= shreg_ff[0] ^ baud_control_ff[`SSM_BC_DPOL];
            serial_data_pin_oe <= tx_mode;
        end
    end

    // Read channel; the shift register has no read address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                unique case (s_axi_araddr)
                    `SSM_OFF_BAUDCON: s_axi_rdata <= {24'h000000, baud_control_ff};
                    `SSM_OFF_RCSTA: s_axi_rdata <= {24'h000000, receive_status_control_ff};
                    `SSM_OFF_DIVLO: s_axi_rdata <= {24'h000000, baud_divisor_low_ff};
                    `SSM_OFF_DIVHI: s_axi_rdata <= {24'h000000, baud_divisor_high_ff};
                    `SSM_OFF_TXSTA: s_axi_rdata <= {24'h000000, transmit_status_control_ff};
                    `SSM_OFF_RXDATA: s_axi_rdata <= {24'h000000, rx_data_ff};
                    `SSM_OFF_TXHOLD: s_axi_rdata <= 32'h00000000;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Bit count never exceeds nine while shifting
    bits_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
        shreg_busy_ff |-> bits_left_ff <= 4'h9) else $error("bit count out of range");
    no_tx_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !tx_mode |=> !shreg_busy_ff) else $error("shifting without transmit mode");
    clk_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (state_ff != ssm_pkg::SSM_LEAD) |=> serial_clock_pin_o
        == $past(baud_control_ff[`SSM_BC_CPOL])) else $error("clock idle level wrong");
    data_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == ssm_pkg::SSM_LEAD) && $past(state_ff == ssm_pkg::SSM_LEAD)
        |-> $stable(shreg_ff)) else $error("data moved inside a bit");
    load_now_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_mode && hold_full_ff && state_ff == ssm_pkg::SSM_IDLE |=> shreg_busy_ff)
        else $error("idle shifter did not load");
    hold_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
        shreg_busy_ff && hold_full_ff && $past(hold_full_ff) |-> $stable(hold_ff))
        else $error("holding data lost");
    clk_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        master_on |=> serial_clock_pin_oe) else $error("clock driver off");
    data_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_mode |=> serial_data_pin_oe) else $error("data driver off");
    wake_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        baud_control_ff[`SSM_BC_WAKE] && rx_sync && !rx_prev_ff
        |=> !baud_control_ff[`SSM_BC_WAKE]) else $error("wake not cleared");
endmodule

// ==== tb/ssm_slave_model.sv ====
// Behavioural slave on the two serial pins: samples data on each trailing clock edge.
// Assumes it is clocked by aclk and that the master owns the data line while sending.
`timescale 1ns/1ns
module ssm_slave_model (
    input wire logic aclk,
    input wire logic pol,
    input wire logic sclk,
    input wire logic dline,
    output logic fill
);
    bit q[$];
    int glitch;
    time last_t, per;
    logic pc, pd;
    // Released line shows a pattern that changes every cycle, never the last value
    initial fill = 1'b0;
    always @(posedge aclk) fill <= ~fill;
    // Edges are found on aclk samples so pin update order cannot race the model
    always @(posedge aclk) begin
        if (pc === ~pol && sclk === pol) begin
            q.push_back(dline);
            per = $time - last_t;
            last_t = $time;
        end
        if (pc === ~pol && sclk === ~pol && pd !== dline) glitch++;
        pc <= sclk;
        pd <= dline;
    end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial master: register bus, frames, polarity and modes.
// Assumes the slave model on the pins and the defs header on the include path.
`timescale 1ns/1ns
`include "ssm_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pol, nb;
    logic awready, wready, bvalid, arready, rvalid, d_o, d_oe, c_o, c_oe, fill;
    logic [7:0] awaddr, araddr, b;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    int error_cnt, checks;
    bit exp_q[$];
    wire logic d_i = d_oe ? d_o : fill;
    ssm_top i_ssm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_data_pin_i(d_i), .serial_data_pin_o(d_o),
        .serial_data_pin_oe(d_oe), .serial_clock_pin_o(c_o), .serial_clock_pin_oe(c_oe));
    ssm_slave_model i_ssm_slave_model (.aclk(aclk), .pol(pol), .sclk(c_o), .dline(d_i),
        .fill(fill));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Single exit point for both verdicts
    task automatic final_report();
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // A wait that used up its bound is a failure
    task automatic limit(input int n);
        if (n >= 400) begin
            error_cnt++;
            final_report();
        end
    endtask
    // Bus tasks start just after an edge and end one edge after release
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1; n = 0;
        do begin
            @(posedge aclk); n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 400);
        r = bresp; bready <= 1'b0; limit(n); @(posedge aclk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1; n = 0;
        do begin
            @(posedge aclk); n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 400);
        d = rdata; r = rresp; rready <= 1'b0; limit(n); @(posedge aclk);
    endtask
    // Expected bits: low bit first, ninth last, inverted when data polarity set
    task automatic frame(input logic [7:0] v, input bit nine, input bit ninth, input bit inv);
        for (int i = 0; i < 8; i++) exp_q.push_back(v[i] ^ inv);
        if (nine) exp_q.push_back(ninth ^ inv);
        wr(`SSM_OFF_TXHOLD, {24'h0, v}, rs);
    endtask
    task automatic drain();
        int n;
        for (n = 0; n < 400 && i_ssm_slave_model.q.size() < exp_q.size(); n++) @(posedge aclk);
        limit(n);
        n = 0;
        do begin
            rd_reg(`SSM_OFF_TXSTA, rd, rs); n++;
        end while (rd[`SSM_TS_TRMT] !== 1'b1 && n < 400);
        limit(n);
        `CHK("bit count", exp_q.size(), i_ssm_slave_model.q.size())
        foreach (exp_q[i]) `CHK("data bit", exp_q[i], i_ssm_slave_model.q[i])
        `CHK("data steady", 0, i_ssm_slave_model.glitch)
        `CHK("clock idle", pol, c_o)
        `CHK("bit period", 64'd80, i_ssm_slave_model.per)
        exp_q = {};
    endtask
    task automatic settle();
        repeat (6) @(posedge aclk);
        i_ssm_slave_model.q = {};
        i_ssm_slave_model.glitch = 0;
    endtask
    initial begin
        void'($urandom(32'h7af9));
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf; pol = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_reg(`SSM_OFF_TXSTA, rd, rs);
        `CHK("status reset", {24'h0, `SSM_RST_TXSTA}, rd)
        rd_reg(`SSM_OFF_BAUDCON, rd, rs);
        `CHK("baud reset", 32'h0, rd)
        wr(8'h1c, 32'h5, rs);
        `CHK("unmapped write", 2'b10, rs)
        rd_reg(8'h1c, rd, rs);
        `CHK("unmapped read", 2'b10, rs)
        // Half period of four cycles gives an 80 ns bit clock
        wr(`SSM_OFF_DIVLO, 32'h1, rs);
        wr(`SSM_OFF_RCSTA, 32'h80, rs);
        for (int c = 0; c < 8; c++) begin
            nb = 1'($urandom);
            b = 8'($urandom);
            wr(`SSM_OFF_BAUDCON, {26'h0, c[1], c[0], 4'h8}, rs);
            wr(`SSM_OFF_TXSTA, {24'h0, 1'b1, c[2], 4'b1101, 1'b0, nb}, rs);
            pol <= c[0];
            settle();
            `CHK("clock driver", 1'b1, c_oe)
            `CHK("data driver", 1'b1, d_oe)
            // Second write lands while the first character still shifts
            frame(b, c[2], nb, c[1]);
            frame(~b, c[2], nb, c[1]);
            drain();
        end
        wr(`SSM_OFF_TXSTA, 32'h94, rs);
        settle();
        wr(`SSM_OFF_TXHOLD, 32'ha5, rs);
        repeat (200) @(posedge aclk);
        `CHK("bits without enable", 0, i_ssm_slave_model.q.size())
        wr(`SSM_OFF_RCSTA, 32'ha0, rs);
        wr(`SSM_OFF_TXSTA, 32'hb4, rs);
        repeat (4) @(posedge aclk);
        `CHK("data driver in receive", 1'b0, d_oe)
        wr(`SSM_OFF_RCSTA, 32'h00, rs);
        repeat (4) @(posedge aclk);
        `CHK("clock driver off", 1'b0, c_oe)
        // Released line toggles, so a rising edge soon ends the armed wake
        wr(`SSM_OFF_BAUDCON, 32'h3, rs);
        rd_reg(`SSM_OFF_BAUDCON, rd, rs);
        `CHK("wake enable", 32'h1, rd)
        final_report();
    end
endmodule
